/* File: include/pulse_shaper_pkg.sv */
/*
  constants, types and the power-up coefficient set of the polyphase
  pulse shaper. assumes nothing of its surroundings.
  // Behaviour
  // - reset response is 15 percent root cosine
  // - four phase banks cycled on each output clock
  // - I and Q filters share one coefficient set
  // - 31 tap products summed per output sample
  // - delay lines advance once per symbol
  // - all arithmetic is two's complement
  // - signed 11-bit offset added per phase
  // - result carried at 20 bits per channel
  // - arithmetic right shift, reset shift five
  // - shift 0 to 15, Q shifted alike
  // - shift amount stored per phase
  // - no saturation, overflow wraps
  // - 196 byte chain, 49 per phase, one port
  // - phase 3 filled first, bytes 48 to 0
  // - output meaningless while download runs
  // - taps packed low, low, shared high byte
  // - bytes 45 to 48 hold tap30, offset, shift
  // - reset table peaks 593, 862, 965, 862
  // - reset offsets zero, shifts five
*/
package pulse_shaper_pkg;
  localparam int PHASES = 4;
  localparam int TAPS = 31;
  localparam int BYTES_PER_PHASE = 49;
  localparam int CHAIN_BYTES = PHASES * BYTES_PER_PHASE;
  localparam int COEF_W = 11;
  localparam int SYM_W = 4;
  localparam int ACC_W = 20;
  localparam int SHIFT_W = 4;
  localparam int OUT_W = 12;
  localparam int PHASE_W = 2;
  localparam int CNT_W = 8;
  // byte layout inside one phase
  localparam int PAIR_BYTES = 3;
  localparam int ODD_LO_OFS = 1;
  localparam int HI_OFS = 2;
  localparam int HI_W = 3;
  localparam int HI_EVEN_LSB = 4;
  localparam int HI_ODD_LSB = 0;
  localparam int OFFSET_SLOT = 31;
  localparam int SHIFT_BYTE = 48;
  localparam logic [SHIFT_W-1:0] DEF_SHIFT = 4'h5;
  localparam int DEF_OFFSET = 0;
  localparam logic [CNT_W-1:0] LAST_LOAD = 8'hC3;

  typedef logic [CHAIN_BYTES-1:0][7:0] chain_t;
  typedef logic [TAPS-1:0][SYM_W-1:0] line_t;
  typedef logic signed [COEF_W-1:0] coef_t;
  typedef logic signed [SYM_W-1:0] sym_t;
  typedef logic signed [ACC_W-1:0] acc_t;
  typedef logic [OUT_W-1:0] out_t;

  // power-up root cosine taps, one row per phase
  localparam int DEF_TAP [PHASES][TAPS] = '{
    '{0,0,0,0,-1,3,-4,8,-14,20,-31,46,-69,107,-191,593,
      593,-191,107,-69,46,-31,20,-14,8,-4,3,-1,0,0,0},
    '{0,-1,0,1,-3,5,-9,13,-19,28,-38,51,-71,105,-184,862,
      257,-95,48,-27,15,-8,3,-1,-1,1,-1,1,0,0,0},
    '{0,-1,0,1,-3,5,-7,10,-13,16,-20,23,-26,28,-29,965,
      -29,28,-26,23,-20,16,-13,10,-7,5,-3,1,0,-1,0},
    '{0,0,0,1,-1,1,-1,-1,3,-8,15,-27,48,-95,257,862,
      -184,105,-71,51,-38,28,-19,13,-9,5,-3,1,0,-1,0}};

  // packs the power-up table into chain byte order
  function automatic chain_t default_chain();
    chain_t ch;
    coef_t v;
    int base;
    ch = '0;
    for (int ph = 0; ph < PHASES; ph++) begin
      for (int t = 0; t <= OFFSET_SLOT; t++) begin
        v = coef_t'((t == OFFSET_SLOT) ? DEF_OFFSET : DEF_TAP[ph][t]);
        base = ph * BYTES_PER_PHASE + (t / 2) * PAIR_BYTES;
        if (t % 2 == 0) begin
          ch[base] = v[7:0];
          ch[base + HI_OFS][HI_EVEN_LSB +: HI_W] = v[COEF_W-1:8];
        end else begin
          ch[base + ODD_LO_OFS] = v[7:0];
          ch[base + HI_OFS][HI_ODD_LSB +: HI_W] = v[COEF_W-1:8];
        end
      end
      ch[ph * BYTES_PER_PHASE + SHIFT_BYTE][SHIFT_W-1:0] = DEF_SHIFT;
    end
    return ch;
  endfunction : default_chain

  localparam chain_t RESET_CHAIN = default_chain();
endpackage : pulse_shaper_pkg

/* File: hw/polyphase_pulse_shaper.sv */
/*
  polyphase root raised cosine pulse shaper for the I and Q symbol
  streams: two 31-tap filters, four phases, shared coefficient chain
  loaded a byte at a time through one write port.
  assumes symbol and sample clocks arrive as pins, each much slower
  than clk_sys (at least three clk_sys periods per high and low
  phase), and that load writes come from logic on clk_sys.
*/
`timescale 1ns/10ps
module polyphase_pulse_shaper
  import pulse_shaper_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic symbol_clock_in,
  input wire logic sample_output_clock,
  input wire logic [SYM_W-1:0] inphase_symbol_in,
  input wire logic [SYM_W-1:0] quadrature_symbol_in,
  input wire logic [7:0] load_data,
  input wire logic load_wr,
  output logic [OUT_W-1:0] inphase_sample,
  output logic [OUT_W-1:0] quadrature_sample,
  output logic [ACC_W-1:0] inphase_full_result,
  output logic [ACC_W-1:0] quadrature_full_result,
  output logic sample_valid,
  output logic config_busy
);

  // one tap (or the offset slot) of one phase out of the chain
  function automatic coef_t coef_of(chain_t ch, int ph, int t);
    int base;
    base = ph * BYTES_PER_PHASE + (t / 2) * PAIR_BYTES;
    if (t % 2 == 0) begin
      return coef_t'({ch[base + HI_OFS][HI_EVEN_LSB +: HI_W], ch[base]});
    end
    return coef_t'({ch[base + HI_OFS][HI_ODD_LSB +: HI_W],
                    ch[base + ODD_LO_OFS]});
  endfunction : coef_of

  // per-phase shift amount, low nibble of the last byte
  function automatic logic [SHIFT_W-1:0] shift_of(chain_t ch, int ph);
    return ch[ph * BYTES_PER_PHASE + SHIFT_BYTE][SHIFT_W-1:0];
  endfunction : shift_of

  // signed sum of 31 products plus the phase offset
  function automatic acc_t mac_of(chain_t ch, int ph, line_t ln);
    acc_t acc;
    acc = acc_t'(coef_of(ch, ph, OFFSET_SLOT));
    for (int k = 0; k < TAPS; k++) begin
      acc = acc + acc_t'(coef_of(ch, ph, k)) * acc_t'(sym_t'(ln[k]));
    end
    return acc;
  endfunction : mac_of

  // arithmetic shift then keep the low bits; wraps, never clips
  function automatic out_t scale(acc_t v, logic [SHIFT_W-1:0] sh);
    acc_t s;
    s = v >>> sh;
    return s[OUT_W-1:0];
  endfunction : scale

  logic sym_clk_s1_r;
  logic sym_clk_s2_r;
  logic sym_clk_s3_r;
  logic out_clk_s1_r;
  logic out_clk_s2_r;
  logic out_clk_s3_r;
  logic [SYM_W-1:0] sym_i_s1_r;
  logic [SYM_W-1:0] sym_i_s2_r;
  logic [SYM_W-1:0] sym_q_s1_r;
  logic [SYM_W-1:0] sym_q_s2_r;
  line_t line_i_r;
  line_t line_q_r;
  line_t line_i_nxt;
  line_t line_q_nxt;
  chain_t chain_r;
  chain_t chain_nxt;
  logic [PHASE_W-1:0] phase_r;
  logic [CNT_W-1:0] load_count_r;
  logic [CNT_W-1:0] load_count_nxt;
  logic busy_r;
  logic busy_nxt;
  acc_t full_i_r;
  acc_t full_q_r;
  out_t sample_i_r;
  out_t sample_q_r;
  logic valid_r;
  logic sym_edge;
  logic out_edge;
  acc_t mac_i;
  acc_t mac_q;
  logic [SHIFT_W-1:0] cur_shift;

  // two flops per pin; the third flop only feeds the edge detect
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sym_clk_s1_r <= 1'b0;
      sym_clk_s2_r <= 1'b0;
      sym_clk_s3_r <= 1'b0;
      out_clk_s1_r <= 1'b0;
      out_clk_s2_r <= 1'b0;
      out_clk_s3_r <= 1'b0;
    end else begin
      sym_clk_s1_r <= symbol_clock_in;
      sym_clk_s2_r <= sym_clk_s1_r;
      sym_clk_s3_r <= sym_clk_s2_r;
      out_clk_s1_r <= sample_output_clock;
      out_clk_s2_r <= out_clk_s1_r;
      out_clk_s3_r <= out_clk_s2_r;
    end
  end

  // symbol data takes the same two stages so it lines up with the edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sym_i_s1_r <= '0;
      sym_i_s2_r <= '0;
      sym_q_s1_r <= '0;
      sym_q_s2_r <= '0;
    end else begin
      sym_i_s1_r <= inphase_symbol_in;
      sym_i_s2_r <= sym_i_s1_r;
      sym_q_s1_r <= quadrature_symbol_in;
      sym_q_s2_r <= sym_q_s1_r;
    end
  end

  // rising edges of the synchronised clocks
  assign sym_edge = sym_clk_s2_r & ~sym_clk_s3_r;
  assign out_edge = out_clk_s2_r & ~out_clk_s3_r;

  // delay lines move only on the symbol clock, newest sample at tap 0
  assign line_i_nxt = sym_edge ?
    {line_i_r[TAPS-2:0], sym_i_s2_r} : line_i_r;
  assign line_q_nxt = sym_edge ?
    {line_q_r[TAPS-2:0], sym_q_s2_r} : line_q_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      line_i_r <= '0;
      line_q_r <= '0;
    end else begin
      line_i_r <= line_i_nxt;
      line_q_r <= line_q_nxt;
    end
  end

  // each write pushes one byte in at index 0; the oldest falls out
  // of index 195. no shadow copy, to save 1568 flops
  assign chain_nxt = load_wr ?
    {chain_r[CHAIN_BYTES-2:0], load_data} : chain_r;

  // download progress: busy from the first write until the 196th
  // a cut download leaves the count part way; the next one ends it
  assign load_count_nxt = !load_wr ? load_count_r :
    (load_count_r == LAST_LOAD) ? '0 : load_count_r + 8'h01;
  assign busy_nxt = !load_wr ? busy_r : (load_count_r != LAST_LOAD);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= RESET_CHAIN;
      load_count_r <= '0;
      busy_r <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
      load_count_r <= load_count_nxt;
      busy_r <= busy_nxt;
    end
  end

  // both branches read the same chain and the same phase
  assign mac_i = mac_of(chain_r, int'(phase_r), line_i_r);
  assign mac_q = mac_of(chain_r, int'(phase_r), line_q_r);
  assign cur_shift = shift_of(chain_r, int'(phase_r));

  // phase counter steps to the next of the four banks on each output clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= '0;
    end else if (out_edge) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // results captured on each output clock with the bank just used
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      full_i_r <= '0;
      full_q_r <= '0;
      sample_i_r <= '0;
      sample_q_r <= '0;
    end else if (out_edge) begin
      full_i_r <= mac_i;
      full_q_r <= mac_q;
      sample_i_r <= scale(mac_i, cur_shift);
      sample_q_r <= scale(mac_q, cur_shift);
    end
  end

  // one-cycle strobe marking a fresh output sample
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= out_edge;
    end
  end

  // outputs straight from flops
  assign inphase_sample = sample_i_r;
  assign quadrature_sample = sample_q_r;
  assign inphase_full_result = full_i_r;
  assign quadrature_full_result = full_q_r;
  assign sample_valid = valid_r;
  assign config_busy = busy_r;

  // checks on the design's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence out_tick_s;
    out_edge;
  endsequence

  sequence sample_out_s;
    ##1 valid_r;
  endsequence

  phase_step_a: assert property (
    out_tick_s |=> phase_r == $past(phase_r) + 2'h1)
    else $error("phase did not advance on output clock");

  phase_hold_a: assert property (
    !out_edge |=> phase_r == $past(phase_r))
    else $error("phase moved without output clock");

  four_phase_a: assert property (
    (out_edge && phase_r == 2'h3) |=> phase_r == 2'h0)
    else $error("phase did not wrap after bank three");

  line_push_a: assert property (
    sym_edge |=> line_i_r[0] == $past(sym_i_s2_r)
      && line_q_r[1] == $past(line_q_r[0]))
    else $error("delay line did not take symbol");

  line_hold_a: assert property (
    !sym_edge |=> line_i_r == $past(line_i_r)
      && line_q_r == $past(line_q_r))
    else $error("delay line moved without symbol clock");

  shared_coef_a: assert property (
    line_i_r == line_q_r |-> mac_i == mac_q)
    else $error("I and Q filters disagree on equal data");

  full_capture_a: assert property (
    out_tick_s |=> full_i_r == $past(mac_i) && full_q_r == $past(mac_q))
    else $error("full result not captured");

  shift_scale_a: assert property (
    out_tick_s |=> sample_i_r == scale(full_i_r, $past(cur_shift)))
    else $error("inphase sample wrongly scaled");

  q_scale_a: assert property (
    out_tick_s |=> sample_q_r == scale(full_q_r, $past(cur_shift)))
    else $error("quadrature sample wrongly scaled");

  valid_pulse_a: assert property (
    out_tick_s |-> sample_out_s ##1 !valid_r)
    else $error("sample strobe not a single pulse");

  chain_push_a: assert property (
    load_wr |=> chain_r[0] == $past(load_data)
      && chain_r[CHAIN_BYTES-1] == $past(chain_r[CHAIN_BYTES-2]))
    else $error("load byte did not enter chain");

  chain_hold_a: assert property (
    !load_wr |=> chain_r == $past(chain_r))
    else $error("chain changed without a write");

  busy_end_a: assert property (
    (load_wr && load_count_r == LAST_LOAD) |=> !busy_r && load_count_r == '0)
    else $error("download did not end after 196 bytes");

  busy_start_a: assert property (
    (load_wr && load_count_r == '0) |=> busy_r)
    else $error("download start not flagged");

  // download counter bookkeeping
  sequence load_step_s;
    load_wr && load_count_r != LAST_LOAD;
  endsequence

  count_step_a: assert property (
    load_step_s |=> load_count_r == $past(load_count_r) + 8'h01)
    else $error("download count did not step");

  count_range_a: assert property (
    load_count_r <= LAST_LOAD)
    else $error("download count out of range");

  busy_mid_a: assert property (
    load_step_s |=> busy_r)
    else $error("busy dropped before the last byte");

  busy_hold_a: assert property (
    !load_wr |=> busy_r == $past(busy_r)
      && load_count_r == $past(load_count_r))
    else $error("download state moved without a write");

  count_busy_a: assert property (
    busy_r == (load_count_r != '0))
    else $error("busy flag and count disagree");

  // results and strobe move only on an output tick
  valid_cause_a: assert property (
    valid_r |-> $past(out_edge))
    else $error("sample strobe without output clock");

  sample_hold_a: assert property (
    !out_edge |=> sample_i_r == $past(sample_i_r)
      && sample_q_r == $past(sample_q_r))
    else $error("sample changed without output clock");

  full_hold_a: assert property (
    !out_edge |=> full_i_r == $past(full_i_r)
      && full_q_r == $past(full_q_r))
    else $error("full result changed without output clock");

  // synchronised edges last one cycle, so each rise acts once
  sym_pulse_a: assert property (
    sym_edge |=> !sym_edge)
    else $error("symbol edge longer than one cycle");

  out_pulse_a: assert property (
    out_tick_s |=> !out_edge)
    else $error("output edge longer than one cycle");

  // an empty line leaves only the phase offset
  offset_only_a: assert property (
    line_i_r == '0 |-> mac_i == acc_t'(coef_of(chain_r, int'(phase_r),
      OFFSET_SLOT)))
    else $error("offset not added to empty line");

endmodule : polyphase_pulse_shaper

/* File: bench/symbol_feed.sv */
/*
  upstream symbol source and output clock pacer for the pulse shaper.
  assumes clk_sys runs and send_symbol is called just after an edge.
*/
`timescale 1ns/10ps
module symbol_feed
  import pulse_shaper_pkg::*;
(
  input wire logic clk_sys,
  output logic sym_clk,
  output logic out_clk,
  output logic [SYM_W-1:0] isym,
  output logic [SYM_W-1:0] qsym
);
  // pins idle low, data defined from time zero
  initial begin
    sym_clk = 1'b0;
    out_clk = 1'b0;
    isym = '0;
    qsym = '0;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cycles

  // one symbol, then four output clocks; each high lasts 4 cycles, each low at least 4
  task automatic send_symbol();
    isym = SYM_W'($urandom);
    qsym = SYM_W'($urandom);
    wait_cycles(1);
    sym_clk = 1'b1;
    wait_cycles(4);
    sym_clk = 1'b0;
    // hold time over: inverted data so a late sample never matches
    isym = ~isym;
    qsym = ~qsym;
    repeat (PHASES) begin
      out_clk = 1'b1;
      wait_cycles(4);
      out_clk = 1'b0;
      wait_cycles(4);
    end
  endtask : send_symbol
endmodule : symbol_feed

/* File: bench/polyphase_pulse_shaper_tb.sv */
/*
  self-checking bench: reference model of both filter branches, power-up
  default settings, then random and bypass settings loaded byte by byte.
  assumes symbol_feed paces the symbol and output clock pins.
*/
`timescale 1ns/10ps
module polyphase_pulse_shaper_tb
  import pulse_shaper_pkg::*;
;
  logic clk_sys, reset_n, load_wr, sym_clk, out_clk;
  logic sample_valid, config_busy;
  logic [SYM_W-1:0] isym, qsym;
  logic [7:0] load_data;
  logic [OUT_W-1:0] i_smp, q_smp;
  logic [ACC_W-1:0] i_full, q_full;
  logic [SHIFT_W-1:0] sh [PHASES];
  logic [7:0] cb [CHAIN_BYTES];
  int fail_count, num_checks, cyc, ph, n_smp, exp_smp;
  int cf [PHASES][TAPS+1];
  int li [TAPS];
  int lq [TAPS];

  polyphase_pulse_shaper dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .symbol_clock_in(sym_clk), .sample_output_clock(out_clk),
    .inphase_symbol_in(isym), .quadrature_symbol_in(qsym),
    .load_data(load_data), .load_wr(load_wr), .inphase_sample(i_smp),
    .quadrature_sample(q_smp), .inphase_full_result(i_full),
    .quadrature_full_result(q_full), .sample_valid(sample_valid),
    .config_busy(config_busy));
  symbol_feed src_u (.clk_sys(clk_sys), .sym_clk(sym_clk),
    .out_clk(out_clk), .isym(isym), .qsym(qsym));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [ACC_W-1:0] full_of(input int p, input bit q);
    int s;
    s = cf[p][TAPS];
    for (int k = 0; k < TAPS; k++) s += cf[p][k] * (q ? lq[k] : li[k]);
    return ACC_W'(s);
  endfunction : full_of

  function automatic logic [OUT_W-1:0] smp_of(input logic [ACC_W-1:0] r,
      input logic [SHIFT_W-1:0] n);
    return OUT_W'($signed(r) >>> n);
  endfunction : smp_of

  task automatic check(input logic [ACC_W-1:0] got,
      input logic [ACC_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // model delay lines move on symbol clock only, newest in tap 0
  always @(posedge sym_clk) begin
    for (int k = TAPS - 1; k > 0; k--) begin
      li[k] = li[k-1];
      lq[k] = lq[k-1];
    end
    li[0] = int'($signed(isym));
    lq[0] = int'($signed(qsym));
  end

  // every produced sample against the model of its phase
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      summarize();
    end else if (reset_n && sample_valid === 1'b1) begin
      n_smp++;
      check(i_full, full_of(ph, 1'b0));
      check(q_full, full_of(ph, 1'b1));
      check(i_smp, smp_of(full_of(ph, 1'b0), sh[ph]));
      check(q_smp, smp_of(full_of(ph, 1'b1), sh[ph]));
      ph = (ph + 1) % PHASES;
    end
  end

  // new settings into model and chain; bypass keeps the centre tap only
  task automatic load(input bit bypass);
    int b;
    logic [COEF_W-1:0] v;
    cb = '{default: 8'hF8}; // spare bits set, must be ignored
    sh = '{4'hF, 4'h0, 4'h3, SHIFT_W'($urandom)};
    if (bypass) sh = '{default: 4'h0};
    for (int p = 0; p < PHASES; p++) begin
      for (int t = 0; t <= TAPS; t++) begin
        cf[p][t] = bypass ? int'(t == 15) : int'($signed(COEF_W'($urandom)));
        v = COEF_W'(cf[p][t]);
        b = p * 49 + (t / 2) * 3;
        if (t % 2 == 0) begin
          cb[b] = v[7:0];
          cb[b+2][6:4] = v[10:8];
        end else begin
          cb[b+1] = v[7:0];
          cb[b+2][2:0] = v[10:8];
        end
      end
      cb[p * 49 + 48][3:0] = sh[p];
    end
    for (int i = CHAIN_BYTES - 1; i >= 0; i--) begin
      load_data = cb[i];
      load_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      if (i == CHAIN_BYTES - 1 || i == 1) check(config_busy, 1'b1);
    end
    load_wr = 1'b0;
    check(config_busy, 1'b0);
  endtask : load

  task automatic run(input int n);
    repeat (n) src_u.send_symbol();
    // four strobes per symbol, none lost and none doubled
    exp_smp += n * PHASES;
    check(ACC_W'(n_smp), ACC_W'(exp_smp));
  endtask : run

  initial begin
    void'($urandom(36222));
    reset_n = 1'b0;
    load_wr = 1'b0;
    load_data = 8'h00;
    ph = 0;
    li = '{default: 0};
    lq = '{default: 0};
    // power-up set: table taps, zero offsets, shift five
    for (int p = 0; p < PHASES; p++) begin
      sh[p] = 4'h5;
      cf[p][TAPS] = 0;
      for (int t = 0; t < TAPS; t++) cf[p][t] = DEF_TAP[p][t];
    end
    repeat (5) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    run(40);
    load(1'b0);
    run(40);
    load(1'b1);
    run(12);
    load(1'b0);
    run(20);
    summarize();
  end
endmodule : polyphase_pulse_shaper_tb
